// *** hdl/upf_port.sv ***
// Parallel FIFO port: receive/transmit buffers, strobe handshake,
// bit-bang modes, flush timer, wake-up and control pins.
// Assumes an AHB-Lite master stands in for the USB protocol engine,
// and all pin inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "upf_regs.svh"

module upf_port import upf_pkg::*; #(
	parameter int DEPTH       = 512,
	parameter int MS_CYCLES   = `UPF_NS_PER_MS / `UPF_CLK_NS,
	parameter int WAKE_CYCLES = `UPF_WAKE_MS * MS_CYCLES,
	parameter upf_cfun_type CF0_RST = UPF_POWER_ENABLE_N,
	parameter upf_cfun_type CF1_RST = UPF_TSTAMP
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        usb_suspend,
	input  wire logic        usb_configured,
	input  wire logic        usb_sof,
	output logic             resume_req,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [7:0]  data_in,
	output logic [7:0]       data_out,
	output logic [7:0]       data_oe,
	output logic             rx_data_avail_n,
	output logic             tx_space_avail_n,
	input  wire logic        wake_request_n,
	output logic [1:0]       config_ctrl_pins_o,
	output logic [1:0]       config_ctrl_pins_oe,
	output logic             high_drive
);
	localparam int CW  = $clog2(DEPTH + 1);
	localparam int WW  = $clog2(WAKE_CYCLES + 1);
	localparam int MW  = $clog2(MS_CYCLES);
	localparam int REC = (`UPF_RECOVER_NS + `UPF_CLK_NS - 1) / `UPF_CLK_NS;

	typedef struct packed {
		upf_mode_type         mode;
		logic [7:0]           dir;
		logic [7:0]           tmo;
		logic [15:0]          bbdiv;
		upf_nvcfg_type        cfg;
		logic                 wr_pend;
		logic [`UPF_AW-1:0]   addr;
		logic                 hrdy;
		logic [31:0]          hrdata;
		logic                 rdp;
		logic                 wrp;
		logic [1:0]           rd_hold;
		logic [1:0]           wr_hold;
		logic [7:0]           dout;
		logic [7:0]           doe;
		logic                 rxa_n;
		logic                 txs_n;
		logic [MW-1:0]        ms_cnt;
		logic [7:0]           idle_ms;
		logic                 flush;
		logic [WW-1:0]        wake_cnt;
		logic                 resume;
		logic                 tstamp;
		logic [1:0]           cbo;
		logic [1:0]           cboe;
		logic [15:0]          bb_cnt;
	} upf_port_state_type;

	upf_port_state_type s_q, s_d;
	upf_byte_type       rx_out, tx_out;
	logic               rx_push, rx_ready, rx_pop;
	logic               tx_push, tx_ready, tx_pop;
	logic [7:0]         tx_din;
	logic [CW-1:0]      rx_cnt, tx_cnt;
	logic [1:0]         cb_o, cb_oe;
	logic               addr_ph, rd_fall, rd_rise, wr_fall, wr_rise, ms_tick, bb_tick;

	// ------------------------------------------------------------
	// Buffers
	// ------------------------------------------------------------
	upf_fifo #(.W(8), .DEPTH(DEPTH)) u_rx (
		.clk       (clk),
		.nrst      (nrst),
		.ce        (ce),
		.in_valid  (rx_push),
		.in_data   (hwdata[7:0]),
		.in_ready  (rx_ready),
		.out_valid (rx_out.valid),
		.out_data  (rx_out.data),
		.out_ready (rx_pop),
		.count     (rx_cnt)
	);

	upf_fifo #(.W(8), .DEPTH(DEPTH)) u_tx (
		.clk       (clk),
		.nrst      (nrst),
		.ce        (ce),
		.in_valid  (tx_push),
		.in_data   (tx_din),
		.in_ready  (tx_ready),
		.out_valid (tx_out.valid),
		.out_data  (tx_out.data),
		.out_ready (tx_pop),
		.count     (tx_cnt)
	);

	// ------------------------------------------------------------
	// Strobe edges, timers
	// ------------------------------------------------------------
	assign addr_ph = hsel && htrans[1] && hready;
	assign rd_fall = s_q.rdp && !rd_n;
	assign rd_rise = !s_q.rdp && rd_n;
	assign wr_fall = s_q.wrp && !wr_n;
	assign wr_rise = !s_q.wrp && wr_n;
	assign ms_tick = s_q.ms_cnt == MW'(MS_CYCLES - 1);
	// Pacing runs off clk; the divisor stands in for the fast-clock prescaler
	assign bb_tick = s_q.bb_cnt == '0;

	always_comb begin
		rx_push = s_q.wr_pend && s_q.addr == `UPF_A_RXPUSH;
		tx_pop  = addr_ph && !hwrite && haddr[`UPF_AW-1:0] == `UPF_A_TXPOP;
		rx_pop  = 1'b0;
		tx_push = 1'b0;
		tx_din  = data_in;
		case (s_q.mode)
			UPF_FIFO: begin
				rx_pop  = rd_fall && rx_out.valid;
				tx_push = wr_fall && tx_ready;
			end
			UPF_ABB: begin
				rx_pop = bb_tick && rx_out.valid;
			end
			UPF_SBB: begin
				// Stalls while the sample buffer is full so no sample is lost
				rx_pop  = bb_tick && rx_out.valid && tx_ready;
				tx_push = rx_pop;
			end
			default: begin
				rx_pop = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Control pins
	// ------------------------------------------------------------
	for (genvar gi = 0; gi < 2; gi++) begin : g_config_ctrl_pins
		always_comb begin
			cb_oe[gi] = 1'b1;
			case (s_q.cfg.cf[gi])
				UPF_TRI:    begin cb_o[gi] = 1'b0; cb_oe[gi] = 1'b0; end
				UPF_DRV1:   cb_o[gi] = 1'b1;
				UPF_DRV0:   cb_o[gi] = 1'b0;
				UPF_POWER_ENABLE_N:  cb_o[gi] = !(usb_configured && !usb_suspend);
				UPF_SLEEP:  cb_o[gi] = !usb_suspend;
				UPF_TSTAMP: cb_o[gi] = s_q.tstamp;
				default:    begin cb_o[gi] = 1'b0; cb_oe[gi] = 1'b0; end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rdp  = rd_n;
		s_d.wrp  = wr_n;
		s_d.hrdy = 1'b1;
		s_d.cbo  = cb_o;
		s_d.cboe = cb_oe;
		s_d.wr_pend = addr_ph && hwrite;
		if (addr_ph) begin
			s_d.addr = haddr[`UPF_AW-1:0];
		end
		// Read data is built in the address phase so it stands from a flop
		if (addr_ph && !hwrite) begin
			case (haddr[`UPF_AW-1:0])
				`UPF_A_RXPUSH: s_d.hrdata = 32'(rx_cnt);
				`UPF_A_TXPOP:  s_d.hrdata = 32'(tx_out);
				`UPF_A_MODE:   s_d.hrdata = {16'h0000, s_q.dir, 6'h00, s_q.mode};
				`UPF_A_TMO:    s_d.hrdata = {24'h000000, s_q.tmo};
				`UPF_A_NVCFG:  s_d.hrdata = {21'h000000, s_q.cfg.cf[1], 1'b0, s_q.cfg.cf[0], 2'b00,
					s_q.cfg.hdrv, s_q.cfg.wake_en};
				`UPF_A_STATUS: s_d.hrdata = {2'b00, usb_suspend, s_q.flush, 12'(tx_cnt), 16'(rx_cnt)};
				`UPF_A_BBDIV:  s_d.hrdata = {16'h0000, s_q.bbdiv};
				`UPF_A_PINS:   s_d.hrdata = {24'h000000, data_in};
				default:       s_d.hrdata = 32'h00000000;
			endcase
		end
		if (s_q.wr_pend) begin
			case (s_q.addr)
				`UPF_A_MODE: begin
					s_d.mode = upf_mode_type'(hwdata[1:0]);
					s_d.dir  = hwdata[`UPF_F_DIR_LO +: 8];
				end
				`UPF_A_TMO: begin
					if (hwdata[7:0] >= `UPF_TMO_MIN) begin
						s_d.tmo = hwdata[7:0];
					end
				end
				`UPF_A_NVCFG: begin
					s_d.cfg.wake_en = hwdata[`UPF_F_WAKE];
					s_d.cfg.hdrv    = hwdata[`UPF_F_HDRV];
					s_d.cfg.cf[0]   = upf_cfun_type'(hwdata[`UPF_F_CF0_LO +: 3]);
					s_d.cfg.cf[1]   = upf_cfun_type'(hwdata[`UPF_F_CF1_LO +: 3]);
				end
				`UPF_A_BBDIV: s_d.bbdiv = hwdata[15:0];
				default: s_d.bbdiv = s_q.bbdiv;
			endcase
		end

		// Read and write recovery: flag held off REC cycles after each strobe
		if (rd_rise) begin
			s_d.rd_hold = 2'(REC);
		end else if (s_q.rd_hold != '0) begin
			s_d.rd_hold = s_q.rd_hold - 2'd1;
		end
		if (wr_rise) begin
			s_d.wr_hold = 2'(REC);
		end else if (s_q.wr_hold != '0) begin
			s_d.wr_hold = s_q.wr_hold - 2'd1;
		end
		s_d.rxa_n = !(s_q.mode == UPF_FIFO && rx_out.valid && !rd_rise && s_d.rd_hold == '0);
		s_d.txs_n = !(s_q.mode == UPF_FIFO && tx_ready && !wr_rise && s_d.wr_hold == '0);

		// Data lines
		case (s_q.mode)
			UPF_FIFO: begin
				if (rx_pop) begin
					s_d.dout = rx_out.data;
				end
				s_d.doe = {8{!rd_n}};
			end
			UPF_ABB, UPF_SBB: begin
				if (rx_pop) begin
					s_d.dout = rx_out.data;
				end
				s_d.doe = s_q.dir;
			end
			default: s_d.doe = 8'h00;
		endcase
		s_d.bb_cnt = bb_tick ? s_q.bbdiv : s_q.bb_cnt - 16'd1;

		// Flush timer: idle time since the last byte entered the transmit buffer
		s_d.ms_cnt = ms_tick ? '0 : s_q.ms_cnt + MW'(1);
		if (tx_push || !tx_out.valid) begin
			s_d.idle_ms = 8'h00;
			s_d.flush   = 1'b0;
		end else if (s_q.idle_ms >= s_q.tmo) begin
			s_d.flush = 1'b1;
		end else if (ms_tick) begin
			s_d.idle_ms = s_q.idle_ms + 8'd1;
		end

		// Wake-up: one resume pulse per qualifying hold of the pin
		s_d.resume = 1'b0;
		if (!(usb_suspend && s_q.cfg.wake_en && !wake_request_n)) begin
			s_d.wake_cnt = '0;
		end else if (s_q.wake_cnt != WW'(WAKE_CYCLES)) begin
			s_d.wake_cnt = s_q.wake_cnt + WW'(1);
			s_d.resume   = s_d.wake_cnt == WW'(WAKE_CYCLES);
		end
		if (usb_sof) begin
			s_d.tstamp = !s_q.tstamp;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Reset input is pulled up at the pad; tied high it never fires
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q            <= '0;
			s_q.mode       <= UPF_FIFO;
			s_q.tmo        <= `UPF_TMO_RST;
			s_q.bbdiv      <= `UPF_BBDIV_RST;
			s_q.cfg        <= '{cf: '{CF1_RST, CF0_RST}, hdrv: 1'b0, wake_en: 1'b1};
			s_q.hrdy       <= 1'b1;
			s_q.rdp        <= 1'b1;
			s_q.wrp        <= 1'b1;
			s_q.rxa_n      <= 1'b1;
			s_q.txs_n      <= 1'b1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign hreadyout           = s_q.hrdy;
	assign hrdata              = s_q.hrdata;
	assign hresp               = 1'b0;
	assign resume_req          = s_q.resume;
	assign data_out            = s_q.dout;
	assign data_oe             = s_q.doe;
	assign rx_data_avail_n     = s_q.rxa_n;
	assign tx_space_avail_n    = s_q.txs_n;
	assign config_ctrl_pins_o  = s_q.cbo;
	assign config_ctrl_pins_oe = s_q.cboe;
	assign high_drive          = s_q.cfg.hdrv;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_rx_recover: assert property (ce && rd_rise |=> rx_data_avail_n ##1 rx_data_avail_n)
		else $error("data flag reasserted too soon after read");
	a_tx_recover: assert property (ce && wr_rise |=> tx_space_avail_n[*2])
		else $error("space flag reasserted too soon after write");
	a_rx_empty: assert property (ce && rx_cnt == '0 |=> rx_data_avail_n)
		else $error("data flag active with empty buffer");
	a_tx_full: assert property (ce && tx_cnt == CW'(DEPTH) |=> tx_space_avail_n)
		else $error("space flag active with full buffer");
	a_tmo_range: assert property (s_q.tmo >= `UPF_TMO_MIN)
		else $error("flush timeout below minimum");
	a_fifo_idle_bus: assert property (ce && s_q.mode == UPF_FIFO && rd_n |=> data_oe == 8'h00)
		else $error("data bus driven with no read strobe");
	a_wake_cause: assert property (resume_req |-> $past(!wake_request_n) && $past(usb_suspend))
		else $error("resume without held wake pin in suspend");
	a_sof_toggle: assert property (ce && usb_sof |=> s_q.tstamp != $past(s_q.tstamp))
		else $error("timestamp did not toggle on frame start");
	a_sync_sample: assert property (ce && s_q.mode == UPF_SBB && tx_push |=> data_out == $past(rx_out.data))
		else $error("sync sample not aligned to applied byte");

	c_fifo_read: cover property (rd_fall && rx_pop);
	c_resume: cover property (resume_req);
	c_sync_bb: cover property (s_q.mode == UPF_SBB && tx_push);
endmodule
`default_nettype wire

// *** hdl/upf_regs.svh ***
// Register offsets, field positions, reset values and timing figures.
// Assumes the includer compares these against a byte address.
`ifndef UPF_REGS_SVH
`define UPF_REGS_SVH
// ------------------------------------------------------------
// Register map (byte offsets)
// ------------------------------------------------------------
`define UPF_AW          8
`define UPF_A_RXPUSH    8'h00
`define UPF_A_TXPOP     8'h04
`define UPF_A_MODE      8'h08
`define UPF_A_TMO       8'h0C
`define UPF_A_NVCFG     8'h10
`define UPF_A_STATUS    8'h14
`define UPF_A_BBDIV     8'h18
`define UPF_A_PINS      8'h1C
// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define UPF_F_DIR_LO    8
`define UPF_F_WAKE      0
`define UPF_F_HDRV      1
`define UPF_F_CF0_LO    4
`define UPF_F_CF1_LO    8
`define UPF_F_TXCNT_LO  16
`define UPF_F_FLUSH     28
`define UPF_F_SUSP      29
`define UPF_F_TXVALID   8
`define UPF_TMO_RST     8'h10
`define UPF_TMO_MIN     8'h02
`define UPF_BBDIV_RST   16'h0030
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define UPF_CLK_NS      40
`define UPF_NS_PER_MS   1000000
`define UPF_WAKE_MS     20
`define UPF_RECOVER_NS  80
`endif

// *** hdl/upf_pkg.sv ***
// Types shared by the parallel FIFO port and its buffers.
// Assumes no other package defines the same names.
package upf_pkg;
	typedef enum logic [1:0] {UPF_FIFO, UPF_ABB, UPF_SBB} upf_mode_type;
	typedef enum logic [2:0] {UPF_TRI, UPF_DRV1, UPF_DRV0, UPF_POWER_ENABLE_N, UPF_SLEEP, UPF_TSTAMP} upf_cfun_type;
	typedef struct packed {
		upf_cfun_type [1:0] cf;
		logic               hdrv;
		logic               wake_en;
	} upf_nvcfg_type;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} upf_byte_type;
endpackage

// *** hdl/upf_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset, clock enable.
`timescale 1ns/1ps
`default_nettype none
module upf_fifo import upf_pkg::*; #(
	parameter int W     = 8,
	parameter int DEPTH = 512,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          ce,
	input  wire logic          in_valid,
	input  wire logic [W-1:0]  in_data,
	output logic               in_ready,
	output logic               out_valid,
	output logic [W-1:0]       out_data,
	input  wire logic          out_ready,
	output logic [CW-1:0]      count
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} upf_fifo_state_type;

	upf_fifo_state_type s_q, s_d;
	logic               push, pop;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign in_ready  = s_q.cnt != CW'(DEPTH);
	assign out_valid = s_q.cnt != '0;
	assign out_data  = s_q.mem[s_q.rp];
	assign count     = s_q.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = step(s_q.wp);
		end
		if (pop) begin
			s_d.rp = step(s_q.rp);
		end
		s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// *** testbench/upf_mcu_model.sv ***
// Model of the external controller on the parallel strobe bus.
// Assumes its tasks are called right after a rising edge, from one process.
`timescale 1ns/1ps
`default_nettype none
module upf_mcu_model (
	input  wire logic       clk,
	input  wire logic       rx_data_avail_n,
	input  wire logic       tx_space_avail_n,
	input  wire logic [7:0] data_out,
	input  wire logic [7:0] data_oe,
	output logic            rd_n,
	output logic            wr_n,
	output logic [7:0]      data_in
);
	logic [7:0] drv_val;
	logic       drv_en;
	// Undriven bits toggle every cycle so a stale level never passes for data
	logic [7:0] float_val = 8'h5A;
	always @(posedge clk) float_val <= ~float_val;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			data_in[i] = data_oe[i] ? data_out[i] : (drv_en ? drv_val[i] : float_val[i]);
		end
	end
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		drv_en = 1'b0;
		drv_val = 8'h00;
	end
	// No local limit: a flag that never comes is left to the bench watchdog
	task automatic wait_flag(input logic want_rx);
		while ((want_rx ? rx_data_avail_n : tx_space_avail_n) !== 1'b0) begin
			@(posedge clk);
		end
	endtask
	// Gap reports the flag three edges after the strobe is released
	task automatic read_byte(input int hold, output logic [7:0] b, output logic gap);
		wait_flag(1'b1);
		rd_n <= 1'b0;
		repeat (hold + 3) @(posedge clk);
		b = data_out;
		rd_n <= 1'b1;
		repeat (3) @(posedge clk);
		gap = rx_data_avail_n;
		@(posedge clk);
	endtask
	task automatic write_byte(input logic [7:0] b, input int hold, output logic gap);
		wait_flag(1'b0);
		drv_val <= b;
		drv_en <= 1'b1;
		wr_n <= 1'b0;
		repeat (hold + 2) @(posedge clk);
		wr_n <= 1'b1;
		repeat (3) @(posedge clk);
		gap = tx_space_avail_n;
		drv_en <= 1'b0;
		@(posedge clk);
	endtask
	// Static levels on the pins that the port leaves undriven
	task automatic drive_pins(input logic en, input logic [7:0] v);
		drv_en <= en;
		drv_val <= v;
	endtask
endmodule
`default_nettype wire

// *** testbench/usb_parallel_fifo_port_bench.sv ***
// Self-checking bench: AHB-Lite host tasks plus the strobe-bus controller model.
// Assumes upf_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "upf_regs.svh"
module usb_parallel_fifo_port_bench import upf_pkg::*;;
	localparam int DEPTH = 8;
	localparam int MSC   = 10;
	localparam int WAKEC = 40;
	logic        clk;
	logic        nrst;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        usb_suspend;
	logic        usb_configured;
	logic        usb_sof;
	logic        resume_req;
	logic        rd_n;
	logic        wr_n;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic [7:0]  data_oe;
	logic        rx_data_avail_n;
	logic        tx_space_avail_n;
	logic        wake_request_n;
	logic [1:0]  pin_o;
	logic [1:0]  pin_oe;
	logic        high_drive;
	int          fail_count = 0;
	int          n_compared = 0;
	int          n_resume = 0;
	logic [31:0] rv;
	logic [7:0]  b;
	logic        gap;
	int          tw[4] = '{1, 2, 255, 0};
	int          te[4] = '{16, 2, 255, 255};
	logic [5:0]  po = 6'b010010;

	upf_port #(.DEPTH(DEPTH), .MS_CYCLES(MSC), .WAKE_CYCLES(WAKEC)) u_upf_port (
		.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .usb_suspend(usb_suspend), .usb_configured(usb_configured),
		.usb_sof(usb_sof), .resume_req(resume_req), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .rx_data_avail_n(rx_data_avail_n),
		.tx_space_avail_n(tx_space_avail_n), .wake_request_n(wake_request_n),
		.config_ctrl_pins_o(pin_o), .config_ctrl_pins_oe(pin_oe), .high_drive(high_drive));
	upf_mcu_model u_upf_mcu_model (
		.clk(clk), .rx_data_avail_n(rx_data_avail_n), .tx_space_avail_n(tx_space_avail_n),
		.data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (resume_req === 1'b1) n_resume <= n_resume + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_rdy;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			@(posedge clk);
		end
	endtask
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(a, 1'b1, d, rv);
	endtask
	task automatic rmask(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		ahb(a, 1'b0, 32'h0, rv);
		chk(rv & m, exp);
	endtask
	task automatic wait_out(input logic [7:0] v, output int n);
		n = 0;
		while (data_out !== v) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic test_done;
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		test_done();
	end

	initial begin
		int  n;
		int  r0;
		logic old;
		nrst = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		usb_suspend = 1'b0;
		usb_configured = 1'b0;
		usb_sof = 1'b0;
		wake_request_n = 1'b1;
		tick(4);
		nrst <= 1'b1;
		tick(1);
		rmask(`UPF_A_TMO, '1, 32'h10);
		rmask(`UPF_A_MODE, '1, 32'h0);
		rmask(`UPF_A_NVCFG, '1, 32'h0531);
		rmask(`UPF_A_BBDIV, '1, 32'h30);
		rmask(8'h20, '1, 32'h0);
		chk(32'(rx_data_avail_n), 32'h1);
		chk(32'(tx_space_avail_n), 32'h0);
		chk(32'(high_drive), 32'h0);
		chk(32'({hreadyout, hresp}), 32'h2);
		$display("reset values test finished");
		// Receive path, one push beyond capacity is dropped
		for (int i = 0; i <= DEPTH; i++) wr(`UPF_A_RXPUSH, 32'hA0 + i);
		rmask(`UPF_A_RXPUSH, '1, 32'(DEPTH));
		for (int i = 0; i < DEPTH; i++) begin
			u_upf_mcu_model.read_byte(i % 2, b, gap);
			chk(32'(b), 32'hA0 + i);
			chk(32'(gap), 32'h1);
		end
		tick(3);
		chk(32'(rx_data_avail_n), 32'h1);
		$display("receive path test finished");
		for (int i = 0; i < DEPTH; i++) begin
			u_upf_mcu_model.write_byte(8'h30 + 8'(i), i % 2, gap);
			chk(32'(gap), 32'h1);
		end
		chk(32'(tx_space_avail_n), 32'h1);
		rmask(`UPF_A_STATUS, '1, 32'(DEPTH) << 16);
		for (int i = 0; i < DEPTH; i++) rmask(`UPF_A_TXPOP, 32'h1FF, 32'h130 + i);
		rmask(`UPF_A_TXPOP, 32'h100, 32'h0);
		$display("transmit path test finished");
		for (int i = 0; i < 4; i++) begin
			wr(`UPF_A_TMO, tw[i]);
			rmask(`UPF_A_TMO, '1, te[i]);
		end
		wr(`UPF_A_TMO, 32'h2);
		u_upf_mcu_model.write_byte(8'h77, 0, gap);
		rmask(`UPF_A_STATUS, 32'h1000_0000, 32'h0);
		tick(2 * MSC + 10);
		rmask(`UPF_A_STATUS, 32'h1000_0000, 32'h1000_0000);
		rmask(`UPF_A_TXPOP, 32'h1FF, 32'h177);
		rmask(`UPF_A_STATUS, 32'h1000_0000, 32'h0);
		$display("timeout test finished");
		wr(`UPF_A_RXPUSH, 32'hA5);
		wr(`UPF_A_RXPUSH, 32'h5A);
		wr(`UPF_A_BBDIV, 32'h3);
		wr(`UPF_A_MODE, 32'hFF01);
		wait_out(8'hA5, n);
		chk(32'(data_oe), 32'hFF);
		chk(32'(rx_data_avail_n), 32'h1);
		wait_out(8'h5A, n);
		chk(n, 32'h4);
		$display("async bit-bang test finished");
		// Upper nibble is input, driven by the controller
		u_upf_mcu_model.drive_pins(1'b1, 8'hC0);
		wr(`UPF_A_MODE, 32'h0F02);
		for (int i = 1; i <= 3; i++) wr(`UPF_A_RXPUSH, i);
		tick(20);
		chk(32'(data_oe), 32'h0F);
		rmask(`UPF_A_PINS, '1, 32'hC3);
		for (int i = 0; i < 3; i++) rmask(`UPF_A_TXPOP, 32'h1F0, 32'h1C0);
		rmask(`UPF_A_TXPOP, 32'h100, 32'h0);
		$display("sync bit-bang test finished");
		usb_configured <= 1'b1;
		wr(`UPF_A_NVCFG, 32'h0503);
		tick(2);
		chk(32'(high_drive), 32'h1);
		for (int k = 0; k < 6; k++) begin
			wr(`UPF_A_NVCFG, 32'h0501 | (k << 4));
			tick(3);
			chk(32'(pin_oe[0]), 32'(k != 0));
			if (k > 0 && k < 5) chk(32'(pin_o[0]), 32'(po[k]));
		end
		wr(`UPF_A_NVCFG, 32'h0531);
		old = pin_o[1];
		usb_sof <= 1'b1;
		tick(1);
		usb_sof <= 1'b0;
		tick(3);
		chk(32'(pin_o[1] != old), 32'h1);
		// A frame start seen while the clock enable is low must not move the pin
		ce <= 1'b0;
		usb_sof <= 1'b1;
		tick(1);
		usb_sof <= 1'b0;
		tick(3);
		ce <= 1'b1;
		chk(32'(pin_o[1] != old), 32'h1);
		usb_suspend <= 1'b1;
		tick(3);
		chk(32'(pin_o[0]), 32'h1);
		$display("control pin test finished");
		r0 = n_resume;
		wake_request_n <= 1'b0;
		tick(WAKEC / 2);
		wake_request_n <= 1'b1;
		tick(4);
		chk(n_resume - r0, 32'h0);
		wake_request_n <= 1'b0;
		tick(WAKEC + 10);
		chk(n_resume - r0, 32'h1);
		wake_request_n <= 1'b1;
		wr(`UPF_A_NVCFG, 32'h0530);
		wake_request_n <= 1'b0;
		tick(WAKEC + 10);
		wake_request_n <= 1'b1;
		chk(n_resume - r0, 32'h1);
		$display("wake test finished");
		wr(`UPF_A_RXPUSH, 32'h11);
		nrst <= 1'b0;
		tick(2);
		chk(32'(data_oe), 32'h0);
		chk(32'({rx_data_avail_n, tx_space_avail_n}), 32'h3);
		nrst <= 1'b1;
		tick(2);
		rmask(`UPF_A_MODE, '1, 32'h0);
		rmask(`UPF_A_TMO, '1, 32'h10);
		rmask(`UPF_A_NVCFG, '1, 32'h0531);
		$display("second reset test finished");
		test_done();
	end
endmodule
`default_nettype wire
